// ### verilog/dbsp_pkg.sv
/*
  shared constants, state codes and the burst index helper for the
  four-word double-data-rate sram port.
  assumes: one user, dbsp_top; everything referenced as dbsp_pkg::name.
*/
package dbsp_pkg;
  // burst shape, fixed: four words, two-bit counter
  localparam int BURST_LEN = 4;
  localparam int BCNT_W = 2;
  localparam logic [1:0] LAST_WORD = 2'h3;
  localparam logic [1:0] FIRST_STEP = 2'h1;
  // one byte lane carries nine data bits
  localparam int LANE_W = 9;
  // output-word countdown
  localparam int OCNT_W = 3;
  localparam logic [2:0] OCNT_FULL = 3'h4;
  // driver impedance code, two ohms per step (scale is arbitrary)
  localparam int CODE_W = 6;
  localparam logic [5:0] IMP_50_CODE = 6'h19;
  // calibration length in input clock periods, counted on true edges
  localparam int CAL_CYCLES = 1024;
  // reference sampling period, system clock at 50 ns
  localparam int SYS_PERIOD_NS = 50;
  localparam int UPD_PERIOD_NS = 1000;
  // longest time: round down, never below one cycle
  localparam int UPD_CYCLES = (UPD_PERIOD_NS / SYS_PERIOD_NS < 1) ? 1 :
                              UPD_PERIOD_NS / SYS_PERIOD_NS;

  // bus cycle sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WR = 2'b01,
    ST_RD = 2'b10
  } dbsp_state_t;

  // linear burst order: start plus step, wrapping in the group of four
  function automatic logic [1:0] burst_idx(input logic [1:0] start,
                                           input logic [1:0] step);
    return start + step;
  endfunction : burst_idx
endpackage : dbsp_pkg

// ### verilog/dbsp_top.sv
/*
  four-word burst double-data-rate sram port: input registers, burst
  counter, posted late write with bypass, read launch, echo clocks,
  impedance code handling and power-up calibration count.
  assumes: LINK_CLK rises once for every rising edge of either input
  clock of the pair, K_TRUE marks the edges of the true one; CLK_SYS is
  unrelated; the master keeps its own turnaround and spacing duties.
*/
// Behaviour
// RULE1: two-bit counter supplies later burst addresses
// RULE2: all synchronous inputs caught in input registers
// RULE3: write data sampled on both clock edges
// RULE4: read data launched on output clocks, else input
// RULE5: master idles one or two cycles read-to-write
// RULE6: read accepted right after a write
// RULE7: last write held posted until next write
// RULE8: next write commits posted write to array
// RULE9: read of posted address served from posting
// RULE10: compare uses address width minus burst bits
// RULE11: compare only with pending write and read
// RULE12: only four-word double-rate bursts offered
// RULE13: low address bits advance linearly each edge
// RULE14: output clocks held high select input clocks
// RULE15: echo clocks opposite, true rises on reference
// RULE16: true echo rising marks first read word
// RULE17: echo clocks always toggle, never high impedance
// RULE18: drivers start at fixed fifty ohm code
// RULE19: calibration needs 1,024 cycles after power-up
// RULE20: impedance updates never disturb an access
// RULE21: clocks may stop; resume without restart
// RULE22: low load strobe on true edge starts cycle
// RULE23: select high reads, low writes, at load
// RULE24: cycle ends after four words, address wraps
// RULE25: byte lane stored only if enable low
// RULE26: master loads at most every second period
// RULE27: data pins driven only for read words
`timescale 1ns/1ps
module dbsp_top #(
  parameter int DW = 18,
  parameter int ADDR_W = 20,
  parameter int CAL_N = dbsp_pkg::CAL_CYCLES,
  parameter int UPD_N = dbsp_pkg::UPD_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic LINK_CLK,
  input wire logic K_TRUE,
  input wire logic LOAD_STROBE_N,
  input wire logic RW_SEL,
  input wire logic [ADDR_W-3:0] UPPER_ADDRESS,
  input wire logic BURST_ADDR_BIT0,
  input wire logic BURST_ADDR_BIT1,
  input wire logic [DW/dbsp_pkg::LANE_W-1:0] BYTE_ENABLE_N,
  input wire logic [DW-1:0] DQ_I,
  output logic [DW-1:0] DQ_O,
  output logic DQ_OE,
  input wire logic OCLK_TRUE,
  input wire logic OCLK_COMP,
  output logic ECHO_CLOCK_TRUE,
  output logic ECHO_CLOCK_COMP,
  input wire logic [dbsp_pkg::CODE_W-1:0] IMPEDANCE_REFERENCE,
  output logic [dbsp_pkg::CODE_W-1:0] DRV_IMPEDANCE,
  output logic CAL_DONE
);
  localparam int BL = dbsp_pkg::BURST_LEN;
  localparam int LW = dbsp_pkg::LANE_W;
  localparam int CW = dbsp_pkg::CODE_W;
  localparam int LANES = DW / LW;
  localparam int ROW_W = ADDR_W - dbsp_pkg::BCNT_W;
  localparam int ROWS = 1 << ROW_W;
  localparam int CAL_W = $clog2(CAL_N + 1);
  localparam int UPD_W = (UPD_N > 1) ? $clog2(UPD_N) : 1;

  // system-side state: reference sampling and code hand-off
  typedef struct packed {
    logic [CW-1:0] zq_s1, zq_s2, zq_prev, code;
    logic [UPD_W-1:0] tick;
    logic req;
    logic ack_s1, ack_s2;
  } dbsp_sys_t;

  // link-side state, clocked by LINK_CLK
  typedef struct packed {
    logic ce_s1, ce_s2;
    logic req_s1, req_s2, ack;
    logic oc_t1, oc_t2, oc_t3, oc_c1, oc_c2, oc_c3;
    logic i_ld_n, i_rw, i_true;
    logic [ROW_W-1:0] i_row;
    logic [1:0] i_lo;
    logic [DW-1:0] i_d;
    logic [LANES-1:0] i_be_n;
    dbsp_pkg::dbsp_state_t st;
    logic [1:0] a_lo, cnt;
    logic post_valid;
    logic [ROW_W-1:0] post_row;
    logic [BL-1:0][DW-1:0] post_d;
    logic [BL-1:0][LANES-1:0] post_m;
    logic [BL-1:0][DW-1:0] obuf;
    logic [dbsp_pkg::OCNT_W-1:0] ocnt;
    logic [DW-1:0] dq_o;
    logic dq_oe, echo_t, echo_c;
    logic [CW-1:0] drv_code;
    logic [CAL_W-1:0] cal_cnt;
    logic cal_done;
  } dbsp_link_t;

  dbsp_sys_t sy_reg, sy_next;
  dbsp_link_t lk_reg, lk_next;

  // array rows of four words each
  logic [BL-1:0][DW-1:0] mem [ROWS];
  logic [BL-1:0][DW-1:0] row_rd; // row addressed by the read load
  logic [BL-1:0][DW-1:0] merged; // row with posted lanes laid over
  logic wr_load, rd_load; // accepted load this edge
  logic hit; // read row equals the posted row
  logic commit_en; // write posted burst into the array
  logic k_tied; // output clock pair held high
  logic cur_true; // this link edge is a true-clock edge
  logic ev_t, ev_c; // reference rising edges, true and complement
  logic link_idle; // no burst and nothing on the data pins

  assign row_rd = mem[lk_reg.i_row];

  // system side: sample the reference, filter, hand the code over
  always_comb begin
    sy_next = sy_reg;
    if (CE) begin
      sy_next.zq_s1 = IMPEDANCE_REFERENCE;
      sy_next.zq_s2 = sy_reg.zq_s1;
      sy_next.zq_prev = sy_reg.zq_s2;
      sy_next.ack_s1 = lk_reg.ack;
      sy_next.ack_s2 = sy_reg.ack_s1;
      if (sy_reg.tick == UPD_W'(UPD_N - 1)) begin
        sy_next.tick = '0;
        // two equal samples in a row, so a moving code is never taken
        if ((sy_reg.req == sy_reg.ack_s2) && (sy_reg.zq_s2 == sy_reg.zq_prev) &&
            (sy_reg.zq_s2 != sy_reg.code)) begin // [RULE20]
          sy_next.code = sy_reg.zq_s2;
          sy_next.req = ~sy_reg.req;
        end
      end else begin
        sy_next.tick = sy_reg.tick + UPD_W'(1);
      end
    end
  end

  // system side registers
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      sy_reg <= '0;
      sy_reg.code <= dbsp_pkg::IMP_50_CODE;
      sy_reg.zq_s1 <= dbsp_pkg::IMP_50_CODE;
      sy_reg.zq_s2 <= dbsp_pkg::IMP_50_CODE;
      sy_reg.zq_prev <= dbsp_pkg::IMP_50_CODE;
    end else begin
      sy_reg <= sy_next;
    end
  end

  // link side: input capture, sequencer, posting, launch, echo
  always_comb begin
    lk_next = lk_reg;
    commit_en = 1'b0;
    hit = 1'b0;
    merged = row_rd;
    k_tied = lk_reg.oc_t2 & lk_reg.oc_c2; // [RULE14]
    cur_true = ~lk_reg.i_true;
    // reference edges: input clocks when tied high, else output pair
    ev_t = k_tied ? cur_true : (lk_reg.oc_t2 & ~lk_reg.oc_t3); // [RULE4]
    ev_c = k_tied ? ~cur_true : (lk_reg.oc_c2 & ~lk_reg.oc_c3); // [RULE4]
    link_idle = (lk_reg.st == dbsp_pkg::ST_IDLE) && (lk_reg.ocnt == '0) &&
                !lk_reg.dq_oe;
    // loads only on a true edge and never inside a running burst
    wr_load = lk_reg.ce_s2 && (lk_reg.st == dbsp_pkg::ST_IDLE) && lk_reg.i_true &&
              !lk_reg.i_ld_n && !lk_reg.i_rw; // [RULE22] [RULE23] [RULE26]
    rd_load = lk_reg.ce_s2 && (lk_reg.st == dbsp_pkg::ST_IDLE) && lk_reg.i_true &&
              !lk_reg.i_ld_n && lk_reg.i_rw; // [RULE6] [RULE22] [RULE23]
    // synchronisers run even while frozen so a restart is seen
    lk_next.ce_s1 = CE;
    lk_next.ce_s2 = lk_reg.ce_s1;
    lk_next.req_s1 = sy_reg.req;
    lk_next.req_s2 = lk_reg.req_s1;
    lk_next.oc_t1 = OCLK_TRUE;
    lk_next.oc_t2 = lk_reg.oc_t1;
    lk_next.oc_c1 = OCLK_COMP;
    lk_next.oc_c2 = lk_reg.oc_c1;
    // static design: a stopped or disabled clock just holds state
    if (lk_reg.ce_s2) begin // [RULE21]
      lk_next.oc_t3 = lk_reg.oc_t2;
      lk_next.oc_c3 = lk_reg.oc_c2;
      // every synchronous input, data on each edge of both clocks
      lk_next.i_ld_n = LOAD_STROBE_N; // [RULE2]
      lk_next.i_rw = RW_SEL; // [RULE2]
      lk_next.i_true = K_TRUE; // [RULE2]
      lk_next.i_row = UPPER_ADDRESS; // [RULE2]
      lk_next.i_lo = {BURST_ADDR_BIT1, BURST_ADDR_BIT0}; // [RULE2]
      lk_next.i_d = DQ_I; // [RULE3]
      lk_next.i_be_n = BYTE_ENABLE_N; // [RULE3]

      // echo pair follows the reference while enabled, holds while frozen
      if (ev_t) begin // [RULE15] [RULE17]
        lk_next.echo_t = 1'b1;
        lk_next.echo_c = 1'b0;
      end else if (ev_c) begin // [RULE15] [RULE17]
        lk_next.echo_t = 1'b0;
        lk_next.echo_c = 1'b1;
      end

      // launch: even words on true edges, odd words on complement
      if ((lk_reg.ocnt != '0) &&
          ((lk_reg.ocnt[0] == 1'b0) ? ev_t : ev_c)) begin // [RULE4] [RULE16]
        lk_next.dq_o = lk_reg.obuf[2'(dbsp_pkg::OCNT_FULL - lk_reg.ocnt)];
        lk_next.dq_oe = 1'b1;
        lk_next.ocnt = lk_reg.ocnt - dbsp_pkg::OCNT_W'(1);
      end else if ((ev_t || ev_c) && (lk_reg.ocnt == '0)) begin
        lk_next.dq_oe = 1'b0; // nothing to deliver: float [RULE27]
      end

      // sequencer: fixed four-word bursts, no rate choice [RULE12]
      if (wr_load) begin
        // a new write retires the one still posted [RULE8]
        commit_en = lk_reg.post_valid;
        lk_next.st = dbsp_pkg::ST_WR;
        lk_next.a_lo = lk_reg.i_lo;
        lk_next.cnt = dbsp_pkg::FIRST_STEP; // [RULE1]
        lk_next.post_valid = 1'b1;
        lk_next.post_row = lk_reg.i_row;
        lk_next.post_m = '0;
        lk_next.post_d[lk_reg.i_lo] = lk_reg.i_d;
        lk_next.post_m[lk_reg.i_lo] = ~lk_reg.i_be_n; // [RULE25]
      end else if (rd_load) begin
        lk_next.st = dbsp_pkg::ST_RD;
        lk_next.a_lo = lk_reg.i_lo;
        lk_next.cnt = dbsp_pkg::FIRST_STEP; // [RULE1]
        // row compare without the two burst bits [RULE10] [RULE11]
        hit = lk_reg.post_valid && (lk_reg.post_row == lk_reg.i_row);
        for (int w = 0; w < BL; w++) begin
          for (int l = 0; l < LANES; l++) begin
            if (hit && lk_reg.post_m[w][l]) begin // [RULE9]
              merged[w][l*LW +: LW] = lk_reg.post_d[w][l*LW +: LW];
            end
          end
        end
        for (int k = 0; k < BL; k++) begin
          lk_next.obuf[k] = merged[dbsp_pkg::burst_idx(lk_reg.i_lo, 2'(k))];
        end
        lk_next.ocnt = dbsp_pkg::OCNT_FULL;
      end else if (lk_reg.st != dbsp_pkg::ST_IDLE) begin
        // later words: counter supplies the low address bits
        if (lk_reg.st == dbsp_pkg::ST_WR) begin // [RULE13]
          lk_next.post_d[dbsp_pkg::burst_idx(lk_reg.a_lo, lk_reg.cnt)] = lk_reg.i_d;
          lk_next.post_m[dbsp_pkg::burst_idx(lk_reg.a_lo, lk_reg.cnt)] =
            ~lk_reg.i_be_n; // [RULE25]
        end
        lk_next.cnt = lk_reg.cnt + dbsp_pkg::FIRST_STEP; // [RULE1] [RULE24]
        if (lk_reg.cnt == dbsp_pkg::LAST_WORD) begin // [RULE24]
          lk_next.st = dbsp_pkg::ST_IDLE;
        end
      end
      // posted write stays put through reads and idle edges [RULE7]

      // new impedance code applied only between accesses [RULE20]
      if ((lk_reg.req_s2 != lk_reg.ack) && link_idle) begin
        lk_next.drv_code = sy_reg.code;
        lk_next.ack = lk_reg.req_s2;
      end

      // power-up calibration window counted on true edges [RULE19]
      if (!lk_reg.cal_done && cur_true) begin
        if (lk_reg.cal_cnt == CAL_W'(CAL_N - 1)) begin
          lk_next.cal_done = 1'b1;
        end
        lk_next.cal_cnt = lk_reg.cal_cnt + CAL_W'(1);
      end
    end
  end

  // link side registers
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lk_reg <= '0;
      lk_reg.i_ld_n <= 1'b1;
      lk_reg.echo_c <= 1'b1;
      lk_reg.drv_code <= dbsp_pkg::IMP_50_CODE; // [RULE18]
    end else begin
      lk_reg <= lk_next;
    end
  end

  // array write of the retired posted burst, lane by lane
  always_ff @(posedge LINK_CLK) begin
    if (commit_en) begin // [RULE8]
      for (int w = 0; w < BL; w++) begin
        for (int l = 0; l < LANES; l++) begin
          if (lk_reg.post_m[w][l]) begin // [RULE25]
            mem[lk_reg.post_row][w][l*LW +: LW] <= lk_reg.post_d[w][l*LW +: LW];
          end
        end
      end
    end
  end

  // all outputs straight from link flops
  assign DQ_O = lk_reg.dq_o;
  assign DQ_OE = lk_reg.dq_oe;
  assign ECHO_CLOCK_TRUE = lk_reg.echo_t;
  assign ECHO_CLOCK_COMP = lk_reg.echo_c;
  assign DRV_IMPEDANCE = lk_reg.drv_code;
  assign CAL_DONE = lk_reg.cal_done;

  // checks on the link side
  chk_burst_step: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE13]
    (lk_reg.ce_s2 && lk_reg.st != dbsp_pkg::ST_IDLE) |=>
      (lk_reg.cnt == $past(lk_reg.cnt) + 2'h1))
    else $error("burst counter did not step by one");
  chk_burst_end: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE24]
    (wr_load || rd_load) ##1 lk_reg.ce_s2 [*3] |=> (lk_reg.st == dbsp_pkg::ST_IDLE))
    else $error("burst did not end after four words");
  chk_first_word: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE16]
    $rose(lk_reg.dq_oe) |-> (lk_reg.echo_t && $past(lk_reg.ocnt) == dbsp_pkg::OCNT_FULL))
    else $error("first read word not on true echo rise");
  chk_echo_anti: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE15]
    lk_reg.echo_t != lk_reg.echo_c)
    else $error("echo clocks not opposite");
  chk_echo_follow: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE17]
    (lk_reg.ce_s2 && k_tied) |=> (lk_reg.echo_t == $past(cur_true)))
    else $error("true echo does not follow the input clock");
  chk_commit_wr: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE8]
    (wr_load && lk_reg.post_valid) |-> commit_en)
    else $error("posted write not committed on next write");
  chk_post_hold: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE7]
    (lk_reg.post_valid && !wr_load) |=>
      (!commit_en || wr_load) && lk_reg.post_row == $past(lk_reg.post_row))
    else $error("posted write lost before next write");
  // a full-mask posted first word must reach the launch buffer unchanged;
  // a broken compare would hand over the stale array word instead
  chk_bypass_hit: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE11]
    (rd_load && lk_reg.post_valid && (lk_reg.post_row == lk_reg.i_row) &&
     (&lk_reg.post_m[lk_reg.i_lo])) |=>
      (lk_reg.obuf[0] == $past(lk_reg.post_d[lk_reg.i_lo])))
    else $error("posted row compare wrong");
  // word0 leaves on the first true edge after the lookup, seen one edge on
  chk_read_launch: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE14]
    (rd_load && k_tied) ##1 (lk_reg.ce_s2 && k_tied) |=>
      (lk_reg.dq_oe && lk_reg.dq_o == $past(lk_reg.obuf[0])))
    else $error("read word not launched on next true edge");
  // every accepted load restarts the counter at the second word
  chk_cnt_start: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE1]
    (wr_load || rd_load) |=> (lk_reg.cnt == dbsp_pkg::FIRST_STEP))
    else $error("burst counter not restarted by load");
  // pins float again on the first reference edge with nothing left
  chk_oe_idle: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE27]
    (lk_reg.ce_s2 && lk_reg.dq_oe && (lk_reg.ocnt == '0) && (ev_t || ev_c)) |=>
      !lk_reg.dq_oe)
    else $error("data pins driven with no read word");
  // once calibrated, the flag never drops until the next reset
  chk_cal_stay: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE19]
    lk_reg.cal_done |=> lk_reg.cal_done)
    else $error("calibration flag dropped");
  chk_cal_done: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE19]
    $rose(lk_reg.cal_done) |-> ($past(lk_reg.cal_cnt) == CAL_W'(CAL_N - 1)))
    else $error("calibration window length wrong");
  chk_imp_idle: assert property (@(posedge LINK_CLK) disable iff (!RSTN) // [RULE20]
    $changed(lk_reg.drv_code) |-> $past(link_idle))
    else $error("impedance code changed during an access");
endmodule : dbsp_top

// ### tb/dbsp_master.sv
/*
  bus master model: makes the input clock edges, drives load, address,
  byte enables and write data, and collects read words in input-clock mode.
  assumes: one link edge per true or comp input edge, 125 ns link period.
*/
`timescale 1ns/1ps
module dbsp_master #(
  parameter int UA_W = 4
) (
  output logic LINK_CLK,
  output logic K_TRUE,
  output logic LOAD_STROBE_N,
  output logic RW_SEL,
  output logic [UA_W-1:0] UPPER_ADDRESS,
  output logic BURST_ADDR_BIT0,
  output logic BURST_ADDR_BIT1,
  output logic [1:0] BYTE_ENABLE_N,
  output logic [17:0] DQ_I,
  output logic OCLK_TRUE,
  output logic OCLK_COMP,
  input wire logic [17:0] DQ_O,
  input wire logic DQ_OE,
  input wire logic ECHO_CLOCK_TRUE
);
  // idle bus at time zero
  initial begin
    LINK_CLK = 1'b0;
    K_TRUE = 1'b0;
    LOAD_STROBE_N = 1'b1;
    RW_SEL = 1'b1;
    UPPER_ADDRESS = '0;
    {BURST_ADDR_BIT1, BURST_ADDR_BIT0} = 2'h0;
    BYTE_ENABLE_N = 2'h3;
    DQ_I = 18'h15a5a;
    OCLK_TRUE = 1'b1; // output clocks not supplied, held high
    OCLK_COMP = 1'b1;
  end
  // free running input clock, never stopped by this model
  always #62.5 LINK_CLK = ~LINK_CLK;
  // true and comp edges alternate
  always @(posedge LINK_CLK) K_TRUE <= #1 ~K_TRUE;
  // loads only on true edges; called just after an edge
  task automatic align();
    while (K_TRUE !== 1'b1) begin
      @(posedge LINK_CLK);
      #2;
    end
  endtask : align
  // write burst: load with word0, one word per edge after
  task automatic wr(input logic [UA_W-1:0] row, input logic [1:0] st,
                    input logic [71:0] d, input logic [7:0] be);
    align();
    RW_SEL = 1'b0; // low selects write
    UPPER_ADDRESS = row;
    {BURST_ADDR_BIT1, BURST_ADDR_BIT0} = st;
    for (int k = 0; k < 4; k++) begin
      LOAD_STROBE_N = (k == 0) ? 1'b0 : 1'b1;
      DQ_I = d[18*k +: 18];
      BYTE_ENABLE_N = be[2*k +: 2];
      @(posedge LINK_CLK);
      #2;
    end
    // released bus: never leave the last word standing
    DQ_I = ~DQ_I;
    BYTE_ENABLE_N = 2'h3;
  endtask : wr
  // read burst; fl = oe at word0, echo at word0, echo at word1, oe after
  task automatic rd(input logic [UA_W-1:0] row, input logic [1:0] st,
                    output logic [71:0] q, output logic [3:0] fl);
    align();
    LOAD_STROBE_N = 1'b0;
    RW_SEL = 1'b1; // high selects read
    UPPER_ADDRESS = row;
    {BURST_ADDR_BIT1, BURST_ADDR_BIT0} = st;
    @(posedge LINK_CLK);
    #2;
    LOAD_STROBE_N = 1'b1;
    DQ_I = ~DQ_I;
    @(posedge LINK_CLK);
    for (int k = 0; k < 4; k++) begin
      @(posedge LINK_CLK);
      #2;
      q[18*k +: 18] = DQ_O;
      if (k == 0) fl[3:2] = {DQ_OE, ECHO_CLOCK_TRUE};
      if (k == 1) fl[1] = ECHO_CLOCK_TRUE;
    end
    // idle edges before any write turnaround
    @(posedge LINK_CLK);
    #2;
    fl[0] = DQ_OE;
  endtask : rd
endmodule : dbsp_master

// ### tb/dbsp_tb_top.sv
/*
  testbench for the burst sram port: reset values, calibration,
  back-to-back write and read, byte lanes with posting, idle bus,
  impedance update and clock stop.
  assumes: dbsp_master as the bus master; memory shrunk to 16 rows.
*/
`timescale 1ns/1ps
module dbsp_tb_top;
  logic clk_sys;
  logic rstn;
  logic ce;
  logic [5:0] imp_ref; // stand-in for the reference resistor
  wire link_clk, k_true, ld_n, rw, b0, b1, oclk_t, oclk_c;
  wire [3:0] ua;
  wire [1:0] be_n;
  wire [17:0] dq_i;
  logic [17:0] dq_o;
  logic dq_oe, echo_t, echo_c, cal_done;
  logic [5:0] drv;
  logic [17:0] mem [0:63]; // expected array, newest data wins
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;

  // small array and short counts keep the run brief
  dbsp_top #(.DW(18), .ADDR_W(6), .CAL_N(8), .UPD_N(2)) DUT (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce), .LINK_CLK(link_clk), .K_TRUE(k_true),
    .LOAD_STROBE_N(ld_n), .RW_SEL(rw), .UPPER_ADDRESS(ua), .BURST_ADDR_BIT0(b0),
    .BURST_ADDR_BIT1(b1), .BYTE_ENABLE_N(be_n), .DQ_I(dq_i), .DQ_O(dq_o),
    .DQ_OE(dq_oe), .OCLK_TRUE(oclk_t), .OCLK_COMP(oclk_c), .ECHO_CLOCK_TRUE(echo_t),
    .ECHO_CLOCK_COMP(echo_c), .IMPEDANCE_REFERENCE(imp_ref), .DRV_IMPEDANCE(drv),
    .CAL_DONE(cal_done));
  dbsp_master #(.UA_W(4)) M (
    .LINK_CLK(link_clk), .K_TRUE(k_true), .LOAD_STROBE_N(ld_n), .RW_SEL(rw),
    .UPPER_ADDRESS(ua), .BURST_ADDR_BIT0(b0), .BURST_ADDR_BIT1(b1),
    .BYTE_ENABLE_N(be_n), .DQ_I(dq_i), .OCLK_TRUE(oclk_t), .OCLK_COMP(oclk_c),
    .DQ_O(dq_o), .DQ_OE(dq_oe), .ECHO_CLOCK_TRUE(echo_t));

  always #25 clk_sys = ~clk_sys;
  // hang guard: far above the expected few hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      results();
    end
  end
  // counted compare, four-state exact
  task automatic check(input string what, input logic [71:0] e, input logic [71:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : check
  // write through the master and mirror it lane by lane
  task automatic wr_m(input logic [3:0] row, input logic [1:0] st,
                      input logic [71:0] d, input logic [7:0] be);
    logic [5:0] ix;
    M.wr(row, st, d, be);
    for (int k = 0; k < 4; k++) begin
      ix = {row, st + 2'(k)};
      if (!be[2*k]) mem[ix][8:0] = d[18*k +: 9];
      if (!be[2*k+1]) mem[ix][17:9] = d[18*k+9 +: 9];
    end
  endtask : wr_m
  // read through the master; words in linear order, flags in k mode
  task automatic rd_c(input logic [3:0] row, input logic [1:0] st);
    logic [71:0] q;
    logic [71:0] e;
    logic [3:0] fl;
    M.rd(row, st, q, fl);
    for (int k = 0; k < 4; k++) e[18*k +: 18] = mem[{row, st + 2'(k)}];
    check("read words", e, q);
    check("read flags", 72'hc, {68'h0, fl});
  endtask : rd_c
  // calibration count finishes in a bounded time
  task automatic t_cal();
    repeat (4) @(posedge link_clk);
    check("cal early", 72'h0, {71'h0, cal_done});
    repeat (20) @(posedge link_clk);
    #2;
    check("cal done", 72'h1, {71'h0, cal_done});
    $display("done cal");
  endtask : t_cal
  // write then read with no gap, wrapping start
  task automatic t_b2b();
    wr_m(4'h3, 2'h1, 72'h0123456789abcdef31, 8'h00);
    rd_c(4'h3, 2'h2);
    $display("done back to back");
  endtask : t_b2b
  // lane codes, commit on next write, posting held across reads
  task automatic t_lanes();
    wr_m(4'h5, 2'h0, 72'h0f0f0f0f0f0f0f0f0f, 8'h00);
    wr_m(4'h5, 2'h0, 72'h123456789abcdef012, 8'he4);
    wr_m(4'h6, 2'h1, 72'hfedcba9876543210ab, 8'h00);
    rd_c(4'h5, 2'h3);
    rd_c(4'h6, 2'h2);
    wr_m(4'h7, 2'h2, 72'h2468ace13579bdf000, 8'h00);
    rd_c(4'h6, 2'h0);
    $display("done lanes");
  endtask : t_lanes
  // no load: data pins off, echoes opposite and toggling
  task automatic t_idle();
    logic p;
    p = echo_t;
    for (int k = 0; k < 8; k++) begin
      @(posedge link_clk);
      #2;
      check("idle pins", 72'h3, {69'h0, dq_oe, echo_t ^ echo_c, echo_t ^ p});
      p = echo_t;
    end
    $display("done idle");
  endtask : t_idle
  // new reference during a read: data intact, code applied later
  task automatic t_imp();
    @(posedge clk_sys);
    #2;
    imp_ref = 6'h2a;
    rd_c(4'h3, 2'h0);
    for (int k = 0; k < 200 && drv !== 6'h2a; k++) @(posedge clk_sys);
    check("impedance", 72'h2a, {66'h0, drv});
    $display("done impedance");
  endtask : t_imp
  // clock stop freezes state; reads work right after resume
  task automatic t_stop();
    logic s;
    @(posedge clk_sys);
    #2;
    ce = 1'b0;
    repeat (4) @(posedge link_clk);
    #2;
    s = echo_t;
    repeat (5) @(posedge link_clk);
    #2;
    check("echo frozen", {71'h0, s}, {71'h0, echo_t});
    @(posedge clk_sys);
    #2;
    ce = 1'b1;
    repeat (3) @(posedge link_clk);
    #2;
    rd_c(4'h7, 2'h1);
    $display("done clock stop");
  endtask : t_stop
  // counts, verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // main sequence
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    imp_ref = 6'h19;
    repeat (20) @(posedge clk_sys);
    check("reset values", 72'h99, {44'h0, dq_o, dq_oe, echo_t, echo_c, cal_done, drv});
    #2;
    rstn = 1'b1;
    t_cal();
    t_b2b();
    t_lanes();
    t_idle();
    t_imp();
    t_stop();
    results();
  end
endmodule : dbsp_tb_top
